// >>> rtl/pfe_frame_encap.sv
`timescale 1ns/1ns
// Operation
// - config alternates C1 then C2, C1=K28.5,D21.5
// - C2 is K28.5, D2.2, two config bytes
// - delimiters S=K27.7, T=K29.7, R=K23.7
// - idle is K28.5 even, data odd
// - tx_en in even slot gives S there
// - tx_en in odd slot: finish idle, S next
// - received S becomes preamble byte
// - dropped preamble byte is not rebuilt
// - T emitted immediately after tx_en falls
// - even/odd alignment held through frame
// - T in even slot followed by one R
// - T in odd slot followed by two R
// - first idle I1 if disparity positive, else I2
// - T,R,R received gives rx_er with 0x0F
module pfe_frame_encap
	import pfe_pkg::*;
(
	input wire logic mclk_i, // character clock
	input wire logic nrst_i, // async reset, active low
	input wire logic gmii_tx_en_i, // client transmit enable
	input wire logic gmii_tx_er_i, // client transmit error
	input wire logic [7:0] gmii_txd_i, // client transmit data
	input wire logic xmit_cfg_i, // send configuration instead of idle
	input wire logic [15:0] cfg_reg_i, // auto-negotiation config value
	input wire logic disp_pos_i, // encoder running disparity positive
	output logic [7:0] tx_code_o, // outgoing code group
	output logic tx_k_o, // outgoing code group is control
	output logic tx_even_o, // outgoing slot is even
	input wire logic [7:0] rx_code_i, // incoming code group
	input wire logic rx_k_i, // incoming code group is control
	output logic [7:0] gmii_rxd_o, // client receive data
	output logic gmii_rx_dv_o, // client receive data valid
	output logic gmii_rx_er_o // client receive error
);
	// ****************************************
	// transmit engine
	// ****************************************
	pfe_tx_e tx_st_q, tx_st_d;
	logic even_q;
	logic [1:0] cfg_idx_q;
	logic cfg_set_q;
	logic first_idle_q;
	logic [7:0] code_d;
	logic k_d;

	function automatic logic is_k(input logic [7:0] c, input logic k, input logic [7:0] ref_c);
		is_k = k && (c == ref_c);
	endfunction

	wire start_now = gmii_tx_en_i && even_q;
	wire odd_q = !even_q;
	wire [7:0] idle_odd = (first_idle_q && disp_pos_i) ? PFE_D5_6 : PFE_D16_2;

	always_comb
	begin
		tx_st_d = tx_st_q;
		code_d = PFE_K28_5;
		k_d = 1'b1;
		case (tx_st_q)
			PFE_TX_IDLE, PFE_TX_CFG:
			begin
				if (start_now && tx_st_q == PFE_TX_IDLE)
				begin
					code_d = PFE_K27_7;
					tx_st_d = PFE_TX_DATA;
				end
				else if ((xmit_cfg_i && even_q) || tx_st_q == PFE_TX_CFG)
				begin
					tx_st_d = (cfg_idx_q == PFE_CFG_LAST && !xmit_cfg_i) ? PFE_TX_IDLE : PFE_TX_CFG;
					k_d = (cfg_idx_q == PFE_CFG_ZERO);
					if (cfg_idx_q == PFE_CFG_ZERO)
						code_d = PFE_K28_5;
					else if (cfg_idx_q == 2'h1)
						code_d = cfg_set_q ? PFE_D2_2 : PFE_D21_5;
					else if (cfg_idx_q == PFE_CFG_LO)
						code_d = cfg_reg_i[7:0];
					else
						code_d = cfg_reg_i[15:8];
				end
				else if (odd_q)
				begin
					code_d = idle_odd;
					k_d = 1'b0;
				end
			end
			PFE_TX_DATA:
			begin
				if (!gmii_tx_en_i)
				begin
					code_d = PFE_K29_7;
					tx_st_d = even_q ? PFE_TX_EXT1 : PFE_TX_EXT2;
				end
				else if (gmii_tx_er_i)
					code_d = PFE_K30_7;
				else
				begin
					code_d = gmii_txd_i;
					k_d = 1'b0;
				end
			end
			PFE_TX_EXT2:
			begin
				code_d = PFE_K23_7;
				tx_st_d = PFE_TX_EXT1;
			end
			PFE_TX_EXT1:
			begin
				code_d = PFE_K23_7;
				tx_st_d = PFE_TX_IDLE;
			end
			default:
				tx_st_d = PFE_TX_IDLE;
		endcase
	end

	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			tx_st_q <= PFE_TX_IDLE;
			even_q <= 1'b1;
			cfg_idx_q <= PFE_CFG_ZERO;
			cfg_set_q <= 1'b0;
			first_idle_q <= 1'b0;
			tx_code_o <= PFE_K28_5;
			tx_k_o <= 1'b1;
			tx_even_o <= 1'b1;
		end
		else
		begin
			even_q <= !even_q;
			tx_st_q <= tx_st_d;
			tx_code_o <= code_d;
			tx_k_o <= k_d;
			tx_even_o <= even_q;
			if (tx_st_d == PFE_TX_CFG || tx_st_q == PFE_TX_CFG)
			begin
				cfg_idx_q <= cfg_idx_q + 2'h1;
				if (cfg_idx_q == PFE_CFG_LAST)
					cfg_set_q <= !cfg_set_q;
			end
			if (tx_st_q == PFE_TX_EXT1)
				first_idle_q <= 1'b1;
			else if (tx_st_q == PFE_TX_IDLE && odd_q)
				first_idle_q <= 1'b0;
		end
	end

	// ****************************************
	// receive engine
	// ****************************************
	pfe_rx_e rx_st_q;
	wire rx_sop = is_k(rx_code_i, rx_k_i, PFE_K27_7);
	wire rx_eop = is_k(rx_code_i, rx_k_i, PFE_K29_7);
	wire rx_ext = is_k(rx_code_i, rx_k_i, PFE_K23_7);
	wire rx_err = is_k(rx_code_i, rx_k_i, PFE_K30_7);

	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			rx_st_q <= PFE_RX_IDLE;
			gmii_rxd_o <= PFE_ZERO;
			gmii_rx_dv_o <= 1'b0;
			gmii_rx_er_o <= 1'b0;
		end
		else
		begin
			gmii_rx_dv_o <= 1'b0;
			gmii_rx_er_o <= 1'b0;
			gmii_rxd_o <= PFE_ZERO;
			case (rx_st_q)
				PFE_RX_IDLE:
					if (rx_sop)
					begin
						gmii_rxd_o <= PFE_PREAMBLE;
						gmii_rx_dv_o <= 1'b1;
						rx_st_q <= PFE_RX_DATA;
					end
				PFE_RX_DATA:
					if (rx_eop)
						rx_st_q <= PFE_RX_EOP;
					else
					begin
						gmii_rxd_o <= rx_code_i;
						gmii_rx_dv_o <= 1'b1;
						gmii_rx_er_o <= rx_err;
					end
				PFE_RX_EOP:
					rx_st_q <= rx_ext ? PFE_RX_EXT : PFE_RX_IDLE;
				PFE_RX_EXT:
				begin
					if (rx_ext)
					begin
						gmii_rx_er_o <= 1'b1;
						gmii_rxd_o <= PFE_EXT_CODE;
					end
					rx_st_q <= PFE_RX_IDLE;
				end
				default:
					rx_st_q <= PFE_RX_IDLE;
			endcase
		end
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!nrst_i);

	sequence s_frame_end;
		tx_st_q == PFE_TX_DATA && !gmii_tx_en_i;
	endsequence

	// last extend, then an even idle slot with no new frame or config
	sequence s_idle_gap;
		tx_st_q == PFE_TX_EXT1 ##1 !gmii_tx_en_i && !xmit_cfg_i;
	endsequence

	chk_sop_even: assert property (tx_st_q == PFE_TX_IDLE && tx_st_d == PFE_TX_DATA |=> tx_code_o == PFE_K27_7 && tx_even_o)
		else $error("start code not in even slot");
	chk_odd_start: assert property (tx_st_q == PFE_TX_IDLE && !xmit_cfg_i && gmii_tx_en_i && odd_q |=> tx_code_o != PFE_K27_7 ##1 tx_code_o == PFE_K27_7)
		else $error("odd start not delayed one slot");
	chk_eop_now: assert property (s_frame_end |=> tx_k_o && tx_code_o == PFE_K29_7)
		else $error("end code not immediate");
	chk_one_ext: assert property (s_frame_end ##0 even_q |=> ##1 tx_code_o == PFE_K23_7 ##1 tx_code_o == PFE_K28_5)
		else $error("even end needs one extend");
	chk_two_ext: assert property (s_frame_end ##0 odd_q |=> ##1 tx_code_o == PFE_K23_7 [*2] ##1 tx_code_o == PFE_K28_5)
		else $error("odd end needs two extends");
	chk_comma_even: assert property (tx_k_o && tx_code_o == PFE_K28_5 |-> tx_even_o)
		else $error("idle comma in odd slot");
	chk_err_prop: assert property (tx_st_q == PFE_TX_DATA && gmii_tx_en_i && gmii_tx_er_i |=> tx_code_o == PFE_K30_7)
		else $error("error not propagated");
	chk_rx_pre: assert property (rx_st_q == PFE_RX_IDLE && rx_sop |=> gmii_rx_dv_o && gmii_rxd_o == PFE_PREAMBLE)
		else $error("start not turned into preamble");
	chk_rx_ext: assert property (rx_eop && rx_st_q == PFE_RX_DATA ##1 rx_ext ##1 rx_ext |=> gmii_rx_er_o && gmii_rxd_o == PFE_EXT_CODE)
		else $error("extension not signalled");
	chk_first_idle: assert property (s_idle_gap ##1 disp_pos_i |=> tx_code_o == PFE_D5_6)
		else $error("correcting idle missing");
endmodule // pfe_frame_encap

// >>> rtl/pfe_pkg.sv
package pfe_pkg;
	// ****************************************
	// code-group encodings (8-bit value, k flag separate)
	// ****************************************
	localparam logic [7:0] PFE_K28_5 = 8'hBC;
	localparam logic [7:0] PFE_D21_5 = 8'hB5;
	localparam logic [7:0] PFE_D2_2 = 8'h42;
	localparam logic [7:0] PFE_D5_6 = 8'hC5;
	localparam logic [7:0] PFE_D16_2 = 8'h50;
	localparam logic [7:0] PFE_K23_7 = 8'hF7;
	localparam logic [7:0] PFE_K27_7 = 8'hFB;
	localparam logic [7:0] PFE_K29_7 = 8'hFD;
	localparam logic [7:0] PFE_K30_7 = 8'hFE;
	localparam logic [7:0] PFE_PREAMBLE = 8'h55;
	localparam logic [7:0] PFE_EXT_CODE = 8'h0F;
	localparam logic [7:0] PFE_ZERO = 8'h00;
	localparam int PFE_CFG_LEN = 4;
	localparam logic [1:0] PFE_CFG_LAST = 2'h3;
	localparam logic [1:0] PFE_CFG_ZERO = 2'h0;
	localparam logic [1:0] PFE_CFG_LO = 2'h2;

	typedef enum {PFE_TX_IDLE, PFE_TX_CFG, PFE_TX_DATA, PFE_TX_EOP, PFE_TX_EXT1, PFE_TX_EXT2} pfe_tx_e;
	typedef enum {PFE_RX_IDLE, PFE_RX_DATA, PFE_RX_EOP, PFE_RX_EXT} pfe_rx_e;
endpackage

// >>> verification/pfe_link_model.sv
`timescale 1ns/1ns
// ********
// far end: echoes each code group one character later
// ********
module pfe_link_model
	import pfe_pkg::*;
(
	input wire logic mclk_i, // character clock
	input wire logic [7:0] code_i, // code group from block
	input wire logic k_i, // control flag from block
	output logic [7:0] code_o, // code group to block
	output logic k_o // control flag to block
);
	always_ff @(posedge mclk_i)
	begin
		code_o <= code_i;
		k_o <= k_i;
	end
endmodule // pfe_link_model

// >>> verification/testbench.sv
`timescale 1ns/1ns
module testbench;
	import pfe_pkg::*;
	logic mclk_i = 0, nrst_i = 0, tx_en = 0, tx_er = 0, cfg = 0, disp = 0;
	logic [7:0] txd = 8'h00;
	logic [15:0] cfg_reg = 16'h1234;
	logic [7:0] tx_code, rx_code, rxd;
	logic tx_k, tx_even, rx_k, dv, er;
	logic [19:0] lq[$];
	int n_errors = 0, checks_done = 0, cyc = 0;
	always #20 mclk_i = ~mclk_i;
	pfe_frame_encap i_dut (.mclk_i(mclk_i), .nrst_i(nrst_i), .gmii_tx_en_i(tx_en), .gmii_tx_er_i(tx_er),
		.gmii_txd_i(txd), .xmit_cfg_i(cfg), .cfg_reg_i(cfg_reg), .disp_pos_i(disp), .tx_code_o(tx_code),
		.tx_k_o(tx_k), .tx_even_o(tx_even), .rx_code_i(rx_code), .rx_k_i(rx_k), .gmii_rxd_o(rxd),
		.gmii_rx_dv_o(dv), .gmii_rx_er_o(er));
	pfe_link_model i_link (.mclk_i(mclk_i), .code_i(tx_code), .k_i(tx_k), .code_o(rx_code), .k_o(rx_k));
	// ********
	// stream log and checking helpers
	// ********
	always @(negedge mclk_i)
	begin
		lq.push_back({tx_even, tx_k, tx_code, er, dv, rxd});
		cyc++;
		if (cyc > 2000)
		begin
			n_errors++;
			summarize();
		end
	end
	function automatic logic [9:0] tx(int i);
		return {1'b0, lq[i][18:10]};
	endfunction
	function automatic int find(logic [9:0] v);
		for (int i = 1; i < lq.size(); i++)
			if (tx(i) === v)
				return i;
		return 1;
	endfunction
	task automatic check(string what, logic [9:0] seen, logic [9:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic summarize();
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// ********
	// scenarios
	// ********
	task automatic config_sets();
		int i;
		lq.delete();
		@(posedge mclk_i);
		cfg <= 1;
		repeat (20) @(posedge mclk_i);
		cfg <= 0;
		repeat (8) @(posedge mclk_i);
		i = find({2'b00, PFE_D21_5}) - 1;
		check("c1 comma", lq[i][19:10], {1'b1, 1'b1, PFE_K28_5});
		check("c1 low", tx(i + 2), {2'b00, cfg_reg[7:0]});
		check("c1 high", tx(i + 3), {2'b00, cfg_reg[15:8]});
		check("c2 comma", tx(i + 4), {2'b01, PFE_K28_5});
		check("c2 id", tx(i + 5), {2'b00, PFE_D2_2});
		check("c2 low", tx(i + 6), {2'b00, cfg_reg[7:0]});
		check("c2 high", tx(i + 7), {2'b00, cfg_reg[15:8]});
		check("c1 again", tx(i + 9), {2'b00, PFE_D21_5});
	endtask
	task automatic frame(int n, bit odd, bit dpos, int erb);
		int s, t, r, f, g;
		lq.delete();
		do
		begin
			@(posedge mclk_i);
			#1;
		end
		while (tx_even !== !odd);
		for (int j = 0; j < n; j++)
		begin
			@(posedge mclk_i);
			tx_en <= 1;
			disp <= dpos;
			txd <= 8'h20 + 8'(j);
			tx_er <= (j == erb);
		end
		@(posedge mclk_i);
		tx_en <= 0;
		tx_er <= 0;
		repeat (14) @(posedge mclk_i);
		s = find({2'b01, PFE_K27_7});
		r = ((n - odd) % 2) ? 2 : 1;
		t = s + n - odd;
		check("sop slot", {9'h0, lq[s][19]}, 10'h1);
		check("before sop", tx(s - 1), {2'b00, PFE_D16_2});
		for (int k = 1; k < n - odd; k++)
			check("data", tx(s + k), (erb == k + odd) ? {2'b01, PFE_K30_7} : {2'b00, 8'h20 + 8'(k + odd)});
		check("eop", tx(t), {2'b01, PFE_K29_7});
		check("extend", tx(t + r), {2'b01, PFE_K23_7});
		check("idle comma", lq[t + r + 1][19:10], {2'b11, PFE_K28_5});
		check("first idle", tx(t + r + 2), {2'b00, dpos ? PFE_D5_6 : PFE_D16_2});
		check("next idle", tx(t + r + 4), {2'b00, PFE_D16_2});
		f = 1;
		while (f < lq.size() && lq[f][8] !== 1'b1)
			f++;
		g = f + n - odd;
		check("rx preamble", lq[f][9:0], {2'b01, PFE_PREAMBLE});
		check("rx data", lq[f + 1][9:0], {2'b01, 8'h21 + 8'(odd)});
		if (erb < n)
			check("rx error", lq[f + erb - odd][9:0], {2'b11, PFE_K30_7});
		check("rx last", lq[g - 1][9:0] & 10'h100, 10'h100);
		check("rx end", lq[g][9:0] & 10'h100, 10'h0);
		check("rx extend", lq[g + 2][9:0] & (r == 2 ? 10'h3FF : 10'h200), r == 2 ? {2'b10, PFE_EXT_CODE} : 10'h0);
	endtask
	initial
	begin
		repeat (4) @(posedge mclk_i);
		nrst_i <= 1;
		config_sets();
		frame(6, 0, 0, 99);
		frame(6, 1, 1, 3);
		summarize();
	end
endmodule // testbench
